// *** src/mdau_pkg.sv ***
/*
 Constants for the multiply/divide arithmetic unit: register
 addresses on page 1, field positions, codes and timing counts.
 Assumes an 8-bit special-function register bus from the core.
*/
package mdau_pkg;
	// ==========================================
	// register addresses
	localparam logic [7:0] ADDR_A_LO = 8'hA2;
	localparam logic [7:0] ADDR_A_HI = 8'hA3;
	localparam logic [7:0] ADDR_C_B0 = 8'hA4;
	localparam logic [7:0] ADDR_C_B1 = 8'hA5;
	localparam logic [7:0] ADDR_C_B2 = 8'hA6;
	localparam logic [7:0] ADDR_C_B3 = 8'hA7;
	localparam logic [7:0] ADDR_DIV_ALIAS = 8'hB1;
	localparam logic [7:0] ADDR_B_LO = 8'hB2;
	localparam logic [7:0] ADDR_B_HI = 8'hB3;
	localparam logic [7:0] ADDR_RES_B0 = 8'hB4;
	localparam logic [7:0] ADDR_RES_B1 = 8'hB5;
	localparam logic [7:0] ADDR_RES_B2 = 8'hB6;
	localparam logic [7:0] ADDR_RES_B3 = 8'hB7;
	localparam logic [7:0] ADDR_CFG_ONE = 8'hC2;
	localparam logic [7:0] ADDR_CFG_TWO = 8'hC3;
	// ==========================================
	// field positions
	localparam int CFG1_TRIGGER = 7;
	localparam int CFG1_CAP_MODE = 6;
	localparam int CFG1_OV_CAP = 5;
	localparam int CFG1_VIEW = 4;
	localparam int CFG1_SRC_HI = 3;
	localparam int CFG1_SRC_LO = 2;
	localparam int CFG1_MUL_HI = 1;
	localparam int CFG1_MUL_LO = 0;
	localparam int CFG2_CLR_HI = 7;
	localparam int CFG2_CLR_LO = 5;
	localparam int CFG2_INTEN = 4;
	localparam logic [7:0] CFG1_RESET = 8'h00;
	// ==========================================
	// codes
	localparam logic [1:0] SRC_ZERO = 2'h0;
	localparam logic [1:0] SRC_PREV = 2'h2;
	localparam logic [1:0] SRC_CONCAT = 2'h3;
	localparam logic [1:0] MUL_SQUARE = 2'h1;
	localparam logic [1:0] MUL_PREV = 2'h2;
	localparam logic [2:0] CLR_A = 3'h1;
	localparam logic [2:0] CLR_B = 3'h2;
	localparam logic [2:0] CLR_C = 3'h3;
	localparam logic [2:0] CLR_PREV = 3'h4;
	localparam logic [2:0] CLR_ALL = 3'h5;
	localparam logic [2:0] CLR_FLAGS = 3'h6;
	localparam logic [15:0] DIV_NEG_MAX = 16'h8000;
	localparam logic [15:0] DIV_MINUS_ONE = 16'hFFFF;
	localparam logic [15:0] DIV_IDLE_DIVIDEND = 16'h0000;
	localparam logic [15:0] DIV_IDLE_DIVISOR = 16'h0001;
	// ==========================================
	// timing
	localparam logic [2:0] DIV_CYCLES = 3'h5;
endpackage

// *** src/mdau_divider.sv ***
/*
 Signed 16-bit divider taking a fixed number of cycles.
 Assumes operands are stable from the start pulse onward.
*/
module mdau_divider (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [15:0] dividend,
	input wire logic [15:0] divisor,
	output logic busy,
	output logic done,
	output logic [15:0] quotient,
	output logic [15:0] remainder
);
	typedef struct packed {
		logic [2:0] count;
		logic done;
		logic [15:0] quot;
		logic [15:0] rem;
	} mdau_div_state_t;

	mdau_div_state_t state_reg, state_next;
	logic out_range;

	// ==========================================
	// datapath
	// out of range pairs give a defined answer, never a trap
	assign out_range = (divisor == 16'h0000) ||
		(dividend == mdau_pkg::DIV_NEG_MAX && divisor == mdau_pkg::DIV_MINUS_ONE);

	always_comb begin
		state_next = state_reg;
		state_next.done = 1'b0;
		if (start) begin
			state_next.count = mdau_pkg::DIV_CYCLES;
		end else if (state_reg.count != 3'h0) begin
			state_next.count = state_reg.count - 3'h1;
			if (state_reg.count == 3'h1) begin
				state_next.done = 1'b1;
				if (out_range) begin
					state_next.quot = dividend;
					state_next.rem = 16'h0000;
				end else begin
					state_next.quot = 16'($signed(dividend) / $signed(divisor));
					state_next.rem = 16'($signed(dividend) % $signed(divisor));
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign busy = (state_reg.count != 3'h0);
	assign done = state_reg.done;
	assign quotient = state_reg.quot;
	assign remainder = state_reg.rem;
endmodule // mdau_divider

// *** src/mdau_shifter.sv ***
/*
 32-bit barrel shifter, purely combinational.
 Assumes the caller registers its output.
*/
module mdau_shifter (
	input wire logic [31:0] data_in,
	input wire logic shift_left,
	input wire logic [4:0] shift_count,
	output logic [31:0] data_out
);
	// ==========================================
	// shift
	// right shift is arithmetic so signed results scale down
	always_comb begin
		if (shift_left) begin
			data_out = data_in << shift_count;
		end else begin
			data_out = 32'($signed(data_in) >>> shift_count);
		end
	end
endmodule // mdau_shifter

// *** src/mdau_top.sv ***
/*
 Multiply / accumulate / divide arithmetic unit behind the
 special-function register bus of a single-cycle core.
 Assumes the core selects page 1 and sets the unit enable
 before touching the registers; both arrive as plain inputs.
*/
// Overview of operation
// - multiply/add/shift one cycle, divide five
// - result follows operands, no start command
// - operands signed; unsigned needs 15-bit operands
// - A,B 16 bits; C, result, previous 32
// - barrel shifter sits before result register
// - trigger reads zero, captures in manual mode
// - auto capture on operand A low write
// - capture result on 32-bit overflow when enabled
// - view select picks current or previous result
// - adder source: zero, C, previous, C
// - source code 11 adds {A,B} to C
// - multiply command: AxB, AxA, AxPrevLow, AxB
// - inactive engine inputs forced to idle values
// - clear field write-only; clears single operand
// - code 101 clears all, 110 flags only
// - interrupt only with enable; divide or overflow
// - range flag on zero divisor or min/-1
// - 16-bit flag on carries from 15, 31
// - 32-bit flag when result exceeds 32 bits
// - flags optionally sticky until software clears
// - quotient high half, remainder low half
// - alias byte write stores, enters divide mode
// - addition: A upper half, B lower half
// - divide result bypasses the shifter
module mdau_top (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic arith_unit_enable,
	input wire logic page_one_selected,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic shift_left,
	input wire logic [4:0] shift_count,
	input wire logic flags_sticky,
	output logic busy,
	output logic irq
);
	typedef struct packed {
		logic [15:0] operand_a;
		logic [15:0] operand_b;
		logic [31:0] accumulator_operand;
		logic [31:0] result_register;
		logic [31:0] previous_result_store;
		logic [6:0] cfg_one;
		logic unit_interrupt_enable;
		logic division_range_flag;
		logic overflow_flag_16;
		logic overflow_flag_32;
		logic div_mode;
		logic [7:0] rdata;
		logic irq;
	} mdau_state_t;

	mdau_state_t state_reg, state_next;

	logic sel;
	logic wr;
	logic rd;
	logic [1:0] adder_source_select;
	logic [1:0] multiply_command;
	logic [15:0] multiplier_input_a;
	logic [15:0] multiplier_input_b;
	logic [15:0] divider_dividend_input;
	logic [15:0] divider_divisor_input;
	logic [31:0] product;
	logic [31:0] adder_in_a;
	logic [31:0] adder_in_b;
	logic [32:0] sum_wide;
	logic [16:0] low_sum;
	logic carry_15;
	logic carry_31;
	logic ovf_32;
	logic [31:0] shifted;
	logic [31:0] result_view;
	logic div_start;
	logic div_busy;
	logic div_done;
	logic [15:0] quotient;
	logic [15:0] remainder;
	logic range_now;
	logic [2:0] clear_code;
	logic cfg_two_wr;

	// ==========================================
	// bus decode
	assign sel = arith_unit_enable && page_one_selected;
	assign wr = sel && sfr_wr;
	assign rd = sel && sfr_rd;
	assign cfg_two_wr = wr && (sfr_addr == mdau_pkg::ADDR_CFG_TWO);
	assign clear_code = cfg_two_wr ?
		sfr_wdata[mdau_pkg::CFG2_CLR_HI:mdau_pkg::CFG2_CLR_LO] : 3'h0;

	assign adder_source_select =
		state_reg.cfg_one[mdau_pkg::CFG1_SRC_HI:mdau_pkg::CFG1_SRC_LO];
	assign multiply_command =
		state_reg.cfg_one[mdau_pkg::CFG1_MUL_HI:mdau_pkg::CFG1_MUL_LO];

	// ==========================================
	// multiplier and adder
	// idle engine inputs keep the unused engine quiet
	always_comb begin
		if (state_reg.div_mode) begin
			multiplier_input_a = 16'h0000;
			multiplier_input_b = 16'h0000;
			divider_dividend_input = state_reg.operand_a;
			divider_divisor_input = state_reg.operand_b;
		end else begin
			multiplier_input_a = state_reg.operand_a;
			divider_dividend_input = mdau_pkg::DIV_IDLE_DIVIDEND;
			divider_divisor_input = mdau_pkg::DIV_IDLE_DIVISOR;
			case (multiply_command)
				mdau_pkg::MUL_SQUARE: begin
					multiplier_input_b = state_reg.operand_a;
				end
				mdau_pkg::MUL_PREV: begin
					multiplier_input_b = state_reg.previous_result_store[15:0];
				end
				default: begin
					multiplier_input_b = state_reg.operand_b;
				end
			endcase
		end
	end

	assign product = 32'($signed(multiplier_input_a) * $signed(multiplier_input_b));

	always_comb begin
		case (adder_source_select)
			mdau_pkg::SRC_ZERO: begin
				adder_in_b = 32'h0000_0000;
			end
			mdau_pkg::SRC_PREV: begin
				adder_in_b = state_reg.previous_result_store;
			end
			default: begin
				adder_in_b = state_reg.accumulator_operand;
			end
		endcase
		if (adder_source_select == mdau_pkg::SRC_CONCAT) begin
			adder_in_a = {state_reg.operand_a, state_reg.operand_b};
		end else begin
			adder_in_a = product;
		end
	end

	assign sum_wide = {1'b0, adder_in_a} + {1'b0, adder_in_b};
	assign low_sum = {1'b0, adder_in_a[15:0]} + {1'b0, adder_in_b[15:0]};
	assign carry_15 = low_sum[16];
	assign carry_31 = sum_wide[32];
	// signed overflow: both inputs agree in sign, sum does not
	assign ovf_32 = !state_reg.div_mode &&
		(adder_in_a[31] == adder_in_b[31]) &&
		(sum_wide[31] != adder_in_a[31]);

	mdau_shifter u_shifter (
		.data_in(sum_wide[31:0]),
		.shift_left(shift_left),
		.shift_count(shift_count),
		.data_out(shifted)
	);

	// ==========================================
	// divider
	// the alias write itself starts a divide, even coming from multiply mode
	assign div_start = wr && (sfr_addr == mdau_pkg::ADDR_DIV_ALIAS ||
		(state_reg.div_mode && (sfr_addr == mdau_pkg::ADDR_A_LO ||
		sfr_addr == mdau_pkg::ADDR_A_HI ||
		sfr_addr == mdau_pkg::ADDR_B_HI)));

	mdau_divider u_divider (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(div_start),
		.dividend(divider_dividend_input),
		.divisor(divider_divisor_input),
		.busy(div_busy),
		.done(div_done),
		.quotient(quotient),
		.remainder(remainder)
	);

	assign range_now = state_reg.div_mode &&
		((divider_divisor_input == 16'h0000) ||
		(divider_dividend_input == mdau_pkg::DIV_NEG_MAX &&
		divider_divisor_input == mdau_pkg::DIV_MINUS_ONE));

	assign result_view = state_reg.cfg_one[mdau_pkg::CFG1_VIEW] ?
		state_reg.previous_result_store : state_reg.result_register;

	// ==========================================
	// next state
	always_comb begin
		state_next = state_reg;
		state_next.irq = 1'b0;
		// result follows operands each cycle in multiply mode
		if (!state_reg.div_mode) begin
			state_next.result_register = shifted;
		end else if (div_done) begin
			state_next.result_register = {quotient, remainder};
		end

		// flags: event sets win over a same-cycle clear
		if (flags_sticky) begin
			state_next.overflow_flag_16 = state_reg.overflow_flag_16;
			state_next.overflow_flag_32 = state_reg.overflow_flag_32;
			state_next.division_range_flag = state_reg.division_range_flag;
		end else begin
			state_next.overflow_flag_16 = 1'b0;
			state_next.overflow_flag_32 = 1'b0;
			state_next.division_range_flag = 1'b0;
		end
		if (clear_code == mdau_pkg::CLR_FLAGS || clear_code == mdau_pkg::CLR_ALL) begin
			state_next.overflow_flag_16 = 1'b0;
			state_next.overflow_flag_32 = 1'b0;
			state_next.division_range_flag = 1'b0;
		end
		if (!state_reg.div_mode && (carry_15 || carry_31)) begin
			state_next.overflow_flag_16 = 1'b1;
		end
		if (ovf_32) begin
			state_next.overflow_flag_32 = 1'b1;
		end
		if (range_now) begin
			state_next.division_range_flag = 1'b1;
		end

		// previous result capture
		if (ovf_32 && state_reg.cfg_one[mdau_pkg::CFG1_OV_CAP]) begin
			state_next.previous_result_store = shifted;
		end
		if (wr && sfr_addr == mdau_pkg::ADDR_A_LO &&
			!state_reg.cfg_one[mdau_pkg::CFG1_CAP_MODE]) begin
			state_next.previous_result_store = state_reg.result_register;
		end
		if (wr && sfr_addr == mdau_pkg::ADDR_CFG_ONE &&
			sfr_wdata[mdau_pkg::CFG1_TRIGGER] &&
			state_reg.cfg_one[mdau_pkg::CFG1_CAP_MODE]) begin
			state_next.previous_result_store = state_reg.result_register;
		end

		// register writes
		if (wr) begin
			case (sfr_addr)
				mdau_pkg::ADDR_A_LO: begin
					state_next.operand_a[7:0] = sfr_wdata;
				end
				mdau_pkg::ADDR_A_HI: begin
					state_next.operand_a[15:8] = sfr_wdata;
				end
				mdau_pkg::ADDR_B_LO: begin
					state_next.operand_b[7:0] = sfr_wdata;
					state_next.div_mode = 1'b0;
				end
				mdau_pkg::ADDR_DIV_ALIAS: begin
					state_next.operand_b[7:0] = sfr_wdata;
					state_next.div_mode = 1'b1;
				end
				mdau_pkg::ADDR_B_HI: begin
					state_next.operand_b[15:8] = sfr_wdata;
				end
				mdau_pkg::ADDR_C_B0: begin
					state_next.accumulator_operand[7:0] = sfr_wdata;
				end
				mdau_pkg::ADDR_C_B1: begin
					state_next.accumulator_operand[15:8] = sfr_wdata;
				end
				mdau_pkg::ADDR_C_B2: begin
					state_next.accumulator_operand[23:16] = sfr_wdata;
				end
				mdau_pkg::ADDR_C_B3: begin
					state_next.accumulator_operand[31:24] = sfr_wdata;
				end
				mdau_pkg::ADDR_CFG_ONE: begin
					// trigger bit is an action, never stored
					state_next.cfg_one = sfr_wdata[6:0];
				end
				mdau_pkg::ADDR_CFG_TWO: begin
					state_next.unit_interrupt_enable = sfr_wdata[mdau_pkg::CFG2_INTEN];
				end
				default: begin
					state_next.div_mode = state_reg.div_mode;
				end
			endcase
		end

		// operand clears
		case (clear_code)
			mdau_pkg::CLR_A: begin
				state_next.operand_a = 16'h0000;
			end
			mdau_pkg::CLR_B: begin
				state_next.operand_b = 16'h0000;
			end
			mdau_pkg::CLR_C: begin
				state_next.accumulator_operand = 32'h0000_0000;
			end
			mdau_pkg::CLR_PREV: begin
				state_next.previous_result_store = 32'h0000_0000;
			end
			mdau_pkg::CLR_ALL: begin
				state_next.operand_a = 16'h0000;
				state_next.operand_b = 16'h0000;
				state_next.accumulator_operand = 32'h0000_0000;
				state_next.previous_result_store = 32'h0000_0000;
				state_next.result_register = 32'h0000_0000;
				state_next.div_mode = 1'b0;
			end
			default: begin
				state_next.operand_a = state_next.operand_a;
			end
		endcase

		// interrupt request, registered; one cycle per divide done, high each cycle that overflow lasts
		state_next.irq = state_reg.unit_interrupt_enable &&
			((state_reg.div_mode && div_done) || ovf_32);

		// read data registered one cycle after the strobe
		if (rd) begin
			case (sfr_addr)
				mdau_pkg::ADDR_A_LO: begin
					state_next.rdata = state_reg.operand_a[7:0];
				end
				mdau_pkg::ADDR_A_HI: begin
					state_next.rdata = state_reg.operand_a[15:8];
				end
				mdau_pkg::ADDR_B_LO, mdau_pkg::ADDR_DIV_ALIAS: begin
					state_next.rdata = state_reg.operand_b[7:0];
				end
				mdau_pkg::ADDR_B_HI: begin
					state_next.rdata = state_reg.operand_b[15:8];
				end
				mdau_pkg::ADDR_C_B0: begin
					state_next.rdata = state_reg.accumulator_operand[7:0];
				end
				mdau_pkg::ADDR_C_B1: begin
					state_next.rdata = state_reg.accumulator_operand[15:8];
				end
				mdau_pkg::ADDR_C_B2: begin
					state_next.rdata = state_reg.accumulator_operand[23:16];
				end
				mdau_pkg::ADDR_C_B3: begin
					state_next.rdata = state_reg.accumulator_operand[31:24];
				end
				mdau_pkg::ADDR_RES_B0: begin
					state_next.rdata = result_view[7:0];
				end
				mdau_pkg::ADDR_RES_B1: begin
					state_next.rdata = result_view[15:8];
				end
				mdau_pkg::ADDR_RES_B2: begin
					state_next.rdata = result_view[23:16];
				end
				mdau_pkg::ADDR_RES_B3: begin
					state_next.rdata = result_view[31:24];
				end
				mdau_pkg::ADDR_CFG_ONE: begin
					state_next.rdata = {1'b0, state_reg.cfg_one};
				end
				mdau_pkg::ADDR_CFG_TWO: begin
					state_next.rdata = {3'h0, state_reg.unit_interrupt_enable, 1'b0,
						state_reg.division_range_flag, state_reg.overflow_flag_16,
						state_reg.overflow_flag_32};
				end
				default: begin
					state_next.rdata = 8'h00;
				end
			endcase
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sfr_rdata = state_reg.rdata;
	assign busy = div_busy;
	assign irq = state_reg.irq;
endmodule // mdau_top

// *** sim/mdau_top_sva.sv ***
/*
 Checker for the arithmetic unit top: bus reads, divide timing, interrupt gating.
 Sees only the top ports; bound to the top at the foot of this file.
*/
module mdau_top_sva (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic arith_unit_enable,
	input wire logic page_one_selected,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic shift_left,
	input wire logic [4:0] shift_count,
	input wire logic flags_sticky,
	input wire logic busy,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic acc_wr;
	logic acc_rd;
	logic inten_reg;
	assign acc_wr = sfr_wr && arith_unit_enable && page_one_selected;
	assign acc_rd = sfr_rd && arith_unit_enable && page_one_selected;
	// shadow of the interrupt enable, followed from accepted writes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			inten_reg <= 1'b0;
		end else if (acc_wr && sfr_addr == mdau_pkg::ADDR_CFG_TWO) begin
			inten_reg <= sfr_wdata[mdau_pkg::CFG2_INTEN];
		end
	end
	// ==========================================
	// properties
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	property p_busy_len;
		$rose(busy) |-> busy[*5] ##1 !busy;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	property p_div_start;
		acc_wr && sfr_addr == mdau_pkg::ADDR_DIV_ALIAS |=> busy;
	endproperty
	a_div_start: assert property (p_div_start) else $error("divide not started");
	property p_busy_cause;
		$rose(busy) |-> $past(acc_wr);
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
	// enable may drop at the edge that launches a registered pulse
	property p_irq_gate;
		irq |-> inten_reg || $past(inten_reg);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
	property p_div_irq;
		$fell(busy) && inten_reg |-> ##[0:1] irq;
	endproperty
	a_div_irq: assert property (p_div_irq) else $error("no irq after divide");
	property p_trig_zero;
		acc_rd && sfr_addr == mdau_pkg::ADDR_CFG_ONE |=> !sfr_rdata[7];
	endproperty
	a_trig_zero: assert property (p_trig_zero) else $error("trigger bit read high");
	property p_clr_zero;
		acc_rd && sfr_addr == mdau_pkg::ADDR_CFG_TWO |=> sfr_rdata[7:5] == 3'h0 && !sfr_rdata[3];
	endproperty
	a_clr_zero: assert property (p_clr_zero) else $error("clear field read high");
	property p_unmapped;
		acc_rd && sfr_addr < mdau_pkg::ADDR_A_LO |=> sfr_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
	property p_rdata_hold;
		!acc_rd |=> $stable(sfr_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	c_div: cover property (acc_wr && sfr_addr == mdau_pkg::ADDR_DIV_ALIAS);
	c_irq: cover property (irq);
	c_done: cover property ($fell(busy));
endmodule // mdau_top_sva
bind mdau_top mdau_top_sva chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
	.arith_unit_enable(arith_unit_enable), .page_one_selected(page_one_selected),
	.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
	.sfr_rdata(sfr_rdata), .shift_left(shift_left), .shift_count(shift_count),
	.flags_sticky(flags_sticky), .busy(busy), .irq(irq));

// *** sim/mdau_core_model.sv ***
/*
 Core-side model driving the register bus of the arithmetic unit.
 Assumes its tasks are entered just after a rising clock edge.
*/
module mdau_core_model (
	input wire logic clk_sys,
	output logic arith_unit_enable,
	output logic page_one_selected,
	output logic [7:0] sfr_addr,
	output logic [7:0] sfr_wdata,
	output logic sfr_wr,
	output logic sfr_rd
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		arith_unit_enable = 1'b0;
		page_one_selected = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
	end
	// ==========================================
	// bus tasks
	task automatic sel(input logic on);
		arith_unit_enable <= on;
		page_one_selected <= on;
	endtask
	// request held over one edge; released only by idle or the next access
	task automatic access(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= is_wr;
		sfr_rd <= !is_wr;
		@(posedge clk_sys);
	endtask
	// released lines show another pattern, never the last value
	task automatic idle();
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b0;
		sfr_addr <= ~sfr_addr;
		sfr_wdata <= ~sfr_wdata;
		@(posedge clk_sys);
	endtask
endmodule // mdau_core_model

// *** sim/tb_top.sv ***
/*
 Self-checking bench for the arithmetic unit, driven through the core model.
 Assumes the checker is bound to the top by its own file.
*/
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst_n, en, pg, wr, rd, rd_d, shl, sticky, busy, irq;
	logic [7:0] addr, wd, rdat;
	logic [4:0] shc, sh;
	logic [3:0] cf;
	logic [15:0] a, b, note;
	logic [31:0] c, e, pv;
	logic [15:0] exp_q[$];
	int err_total, samples_checked, busy_cnt, irq_cnt, n0, i0, seed;
	mdau_core_model core_u (.clk_sys(clk_sys), .arith_unit_enable(en), .page_one_selected(pg),
		.sfr_addr(addr), .sfr_wdata(wd), .sfr_wr(wr), .sfr_rd(rd));
	mdau_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .arith_unit_enable(en),
		.page_one_selected(pg), .sfr_addr(addr), .sfr_wdata(wd), .sfr_wr(wr), .sfr_rd(rd),
		.sfr_rdata(rdat), .shift_left(shl), .shift_count(shc), .flags_sticky(sticky),
		.busy(busy), .irq(irq));
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// ==========================================
	// checking
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			err_total++;
			$display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic give_verdict();
		$display("errors=%0d checks=%0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk_sys) rd_d <= rd & en & pg;
	// read data lands at the read edge; checked on the falling edge after it
	always @(negedge clk_sys) begin
		if (busy === 1'b1) busy_cnt++;
		if (irq === 1'b1) irq_cnt++;
		if (rd_d === 1'b1) begin
			note = exp_q.pop_front();
			check(rdat & note[15:8], note[7:0]);
		end
	end
	initial begin
		#500000;
		err_total++;
		give_verdict();
	end
	// ==========================================
	// stimulus helpers and reference
	function automatic logic [31:0] sx(logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction
	function automatic logic [31:0] calc(logic [3:0] f, logic [15:0] x, logic [15:0] y,
			logic [31:0] z, logic [31:0] p);
		logic [31:0] pr;
		logic [31:0] ad;
		pr = sx(x) * sx(f[1:0] == 2'h1 ? x : f[1:0] == 2'h2 ? p[15:0] : y);
		ad = f[3:2] == 2'h0 ? 32'h0 : f[3:2] == 2'h2 ? p : z;
		return (f[3:2] == 2'h3 ? {x, y} : pr) + ad;
	endfunction
	task automatic w(input logic [7:0] ad, input logic [7:0] d);
		core_u.access(1'b1, ad, d);
	endtask
	task automatic rx(input logic [7:0] ad, input logic [7:0] x, input logic [7:0] m = 8'hFF);
		core_u.access(1'b0, ad, 8'h00);
		exp_q.push_back({m, x & m});
	endtask
	task automatic rres(input logic [31:0] x);
		core_u.idle();
		for (int i = 0; i < 4; i++) rx(mdau_pkg::ADDR_RES_B0 + 8'(i), x[8*i +: 8]);
	endtask
	// low byte of B first, so a previous divide mode is left before A is touched
	task automatic ld(input logic [15:0] x, input logic [15:0] y, input logic [31:0] z);
		w(mdau_pkg::ADDR_B_LO, y[7:0]);
		w(mdau_pkg::ADDR_B_HI, y[15:8]);
		w(mdau_pkg::ADDR_A_HI, x[15:8]);
		w(mdau_pkg::ADDR_A_LO, x[7:0]);
		for (int i = 0; i < 4; i++) w(mdau_pkg::ADDR_C_B0 + 8'(i), z[8*i +: 8]);
	endtask
	// ==========================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		shl = 1'b0;
		shc = 5'h00;
		sticky = 1'b1;
		seed = 18498;
		pv = 32'h0;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		core_u.sel(1'b1);
		@(posedge clk_sys);
		rx(mdau_pkg::ADDR_CFG_ONE, 8'h00);
		rx(mdau_pkg::ADDR_CFG_TWO, 8'h00);
		rx(8'h10, 8'h00);
		rres(32'h0);
		for (int k = 0; k < 8; k++) begin
			cf = {k[2], k[0], k[1:0]};
			a = 16'($random(seed));
			b = 16'($random(seed));
			c = $random(seed);
			ld(a, b, c);
			w(mdau_pkg::ADDR_CFG_ONE, {4'h4, cf});
			e = calc(cf, a, b, c, pv);
			rres(e);
			w(mdau_pkg::ADDR_CFG_ONE, {4'hC, cf});
			rx(mdau_pkg::ADDR_CFG_ONE, {4'h4, cf});
			pv = e;
			w(mdau_pkg::ADDR_CFG_ONE, {4'h5, cf});
			rres(pv);
		end
		w(mdau_pkg::ADDR_CFG_ONE, 8'h04);
		core_u.idle();
		w(mdau_pkg::ADDR_A_LO, a[7:0]);
		w(mdau_pkg::ADDR_CFG_ONE, 8'h14);
		rres(calc(4'h4, a, b, c, pv));
		w(mdau_pkg::ADDR_CFG_ONE, 8'h44);
		e = calc(4'h4, a, b, c, pv);
		shl <= 1'b1;
		shc <= 5'h04;
		rres(e << 4);
		sh = 5'($random(seed));
		shl <= 1'b0;
		shc <= sh;
		rres($signed(e) >>> sh);
		w(mdau_pkg::ADDR_CFG_TWO, 8'h10);
		for (int k = 0; k < 3; k++) begin
			a = k == 1 ? 16'h8000 : 16'($random(seed));
			b = k == 0 ? (16'($random(seed)) | 16'h0001) : k == 1 ? 16'hFFFF : 16'h0000;
			ld(a, b, 32'h0);
			// let overflow pulses from the half-loaded accumulator drain first
			core_u.idle();
			n0 = busy_cnt;
			i0 = irq_cnt;
			w(mdau_pkg::ADDR_DIV_ALIAS, b[7:0]);
			core_u.idle();
			repeat (8) @(posedge clk_sys);
			check(busy_cnt - n0, 5);
			check(irq_cnt - i0, 1);
			e = k == 0 ? {16'($signed(a) / $signed(b)), 16'($signed(a) % $signed(b))} : {a, 16'h0};
			rres(e);
			rx(mdau_pkg::ADDR_CFG_TWO, k == 0 ? 8'h00 : 8'h04, 8'h04);
		end
		shc <= 5'h00;
		w(mdau_pkg::ADDR_CFG_TWO, 8'hD0);
		i0 = irq_cnt;
		w(mdau_pkg::ADDR_CFG_ONE, 8'h74);
		ld(16'h0001, 16'h0001, 32'h7FFFFFFF);
		rres(32'h80000000);
		check(irq_cnt > i0, 1);
		w(mdau_pkg::ADDR_C_B0, 8'h00);
		repeat (3) core_u.idle();
		rx(mdau_pkg::ADDR_CFG_TWO, 8'h03, 8'h03);
		sticky <= 1'b0;
		core_u.idle();
		rx(mdau_pkg::ADDR_CFG_TWO, 8'h00, 8'h03);
		sticky <= 1'b1;
		// raise the flags again so the clear below has work to do
		w(mdau_pkg::ADDR_C_B0, 8'hFF);
		w(mdau_pkg::ADDR_C_B0, 8'h00);
		w(mdau_pkg::ADDR_CFG_TWO, 8'hC0);
		w(mdau_pkg::ADDR_CFG_ONE, 8'h44);
		rx(mdau_pkg::ADDR_CFG_TWO, 8'h00, 8'h03);
		rres(32'h7FFFFF01);
		for (int k = 1; k < 6; k++) begin
			a = 16'($random(seed));
			b = 16'($random(seed));
			c = $random(seed);
			ld(a, b, c);
			w(mdau_pkg::ADDR_CFG_ONE, 8'h4C);
			w(mdau_pkg::ADDR_CFG_TWO, {3'(k), 5'h00});
			rx(mdau_pkg::ADDR_CFG_TWO, 8'h00, 8'hE8);
			e = {k == 1 ? 16'h0 : a, k == 2 ? 16'h0 : b} + (k == 3 ? 32'h0 : c);
			rres(k == 5 ? 32'h0 : e);
		end
		w(mdau_pkg::ADDR_CFG_ONE, 8'h00);
		w(mdau_pkg::ADDR_B_LO, 8'h01);
		core_u.sel(1'b0);
		w(mdau_pkg::ADDR_A_LO, 8'h55);
		core_u.sel(1'b1);
		rres(32'h0);
		core_u.idle();
		give_verdict();
	end
endmodule // tb_top
